// file: rtl/sgw_map.vh
// constants for the configuration port, general port and watchdog
// included by the top-level design file; definitions only
`ifndef SGW_MAP_VH
`define SGW_MAP_VH

// host i/o addresses
`define SGW_IDX_ADDR_A     16'h002E
`define SGW_IDX_ADDR_B     16'h004E
`define SGW_DAT_ADDR_A     16'h002F
`define SGW_DAT_ADDR_B     16'h004F
`define SGW_WDT_UNIT_ADDR  16'h0300
`define SGW_WDT_CNT_ADDR   16'h0301

// configuration keys
`define SGW_KEY_ENTER_A    8'h87
`define SGW_KEY_ENTER_B    8'h77
`define SGW_KEY_EXIT       8'hAA

// configuration register indices
`define SGW_IDX_LDN        8'h07
`define SGW_IDX_ACTIVATE   8'h30
`define SGW_IDX_DIR        8'hF0
`define SGW_IDX_DATA       8'hF1
`define SGW_IDX_INV        8'hF2
`define SGW_LDN_GPIO       8'h07
`define SGW_LDN_WDT        8'h08

// reset values
`define SGW_DIR_RST        8'hFF
`define SGW_DATA_RST       8'h00
`define SGW_INV_RST        8'h00

// watchdog unit codes
`define SGW_UNIT_10MS      8'h00
`define SGW_UNIT_1S        8'h03
`define SGW_UNIT_1MIN      8'h05

// time units in ns and cycles at 10 ns
// 34 bits: one minute of cycles does not fit in 32
`define SGW_CLK_PERIOD_NS  34'h00000000A
`define SGW_T_10MS_NS      34'h000989680
`define SGW_CYC_10MS       (`SGW_T_10MS_NS / `SGW_CLK_PERIOD_NS)
`define SGW_CYC_1S         (34'h000000064 * `SGW_CYC_10MS)
`define SGW_CYC_1MIN       (34'h000001770 * `SGW_CYC_10MS)

`endif

// file: rtl/sgw_tick.v
// time unit tick generator for the watchdog
// assumes one clock; unit select changes restart the divider
`timescale 1ns/1ps
module sgw_tick #(
   parameter [33:0] CYC_10MS = 34'h0000F4240,
   parameter [33:0] CYC_1S   = 34'h005F5E100,
   parameter [33:0] CYC_1MIN = 34'h165A0BC00
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // control
   input  wire        restart_i,
   input  wire [1:0]  unit_sel_i,
   // tick
   output reg         tick_o
);

   reg  [33:0] cnt;
   reg  [33:0] limit;

   always @* begin
      case (unit_sel_i)
         2'd1:    limit = CYC_1S;
         2'd2:    limit = CYC_1MIN;
         default: limit = CYC_10MS;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         cnt    <= 34'h000000000;
         tick_o <= 1'b0;
      end else if (cnt >= limit - 34'h000000001) begin
         cnt    <= 34'h000000000;
         tick_o <= 1'b1;
      end else begin
         cnt    <= cnt + 34'h000000001;
         tick_o <= 1'b0;
      end
   end

endmodule

// file: rtl/sgw_top.v
// configuration port with general i/o port and watchdog timer
// host i/o cycles arrive as one-cycle strobes synchronous to CORE_CLK_I
// Behaviour
// - each direction bit makes its pin an input when one and an output when zero, reset all ones.
// - data bits of output pins are writable and readable, data register resets to zero.
// - data bits of input pins read the sampled pin level and ignore writes.
// - a set inversion bit inverts the value between pin and data register both ways, reset zero.
// - the write-only index port sits at 2Eh or alternatively at 4Eh.
// - the data port at 2Fh or 4Fh reads and writes the register picked by the index.
// - configuration mode opens only after 87H or 77H is written twice in a row to the index port.
// - writing AAH to the index port leaves configuration mode.
// - index 07H holds the logical device number that steers later data accesses.
// - with device 7 selected, indices F0H, F1H and F2H reach direction, data and inversion.
// - on the alternate index port 77h twice enters configuration mode and AAh leaves it.
// - with device 8 selected, register 30h value 01h enables the watchdog and 00h disables it.
// - a write to 300h picks the time unit (00h 10 ms, 03h 1 s, 05h 1 min) and clears timeout.
// - a write to 301h loads the count in selected units and starts the timer.
// - on expiry the device resets the processor or raises an interrupt as configured.
`timescale 1ns/1ps
`include "sgw_map.vh"
module sgw_top #(
   parameter WIDTH    = 8,
   parameter CYC_10MS = `SGW_CYC_10MS,
   parameter CYC_1S   = `SGW_CYC_1S,
   parameter CYC_1MIN = `SGW_CYC_1MIN
) (
   // clock and reset
   input  wire             CORE_CLK_I,
   input  wire             RST_I,
   // host i/o cycle
   input  wire [15:0]      IO_ADDR_I,
   input  wire [7:0]       IO_WDATA_I,
   input  wire             IO_WR_I,
   input  wire             IO_RD_I,
   output reg  [7:0]       IO_RDATA_O,
   output reg              IO_RVALID_O,
   // general port pins
   input  wire [WIDTH-1:0] GPIO_I,
   output reg  [WIDTH-1:0] GPIO_O,
   output reg  [WIDTH-1:0] GPIO_OE_O,
   // watchdog
   input  wire             WDT_IRQ_MODE_I,
   output reg              WDT_RESET_O,
   output reg              WDT_IRQ_O,
   output reg              WDT_TIMEOUT_O
);

   reg  [7:0]       index;
   reg  [7:0]       logical_device_number;
   reg  [1:0]       key_state;
   reg  [1:0]       next_key_state;
   reg  [7:0]       key_last;
   reg  [WIDTH-1:0] port_direction;
   reg  [WIDTH-1:0] port_data;
   reg  [WIDTH-1:0] port_inversion;
   reg  [WIDTH-1:0] pin_sample;
   reg              wdt_enable;
   reg  [1:0]       unit_sel;
   reg  [7:0]       wdt_count;
   reg              wdt_running;
   reg              tick_restart;
   reg  [7:0]       next_rdata;
   wire             tick;
   wire [WIDTH-1:0] data_view;
   wire             idx_hit;
   wire             dat_hit;
   wire             unit_hit;
   wire             cnt_hit;
   wire             cfg_mode;
   wire             is_enter;
   wire             wr_idx;
   wire             wr_dat;
   wire             wr_unit;
   wire             wr_cnt;
   wire             sel_ldn;
   wire             sel_dir;
   wire             sel_data;
   wire             sel_inv;
   wire             sel_act;
   wire             tick_live;
   wire             expire;

   localparam [1:0] KEY_IDLE = 2'h0;
   localparam [1:0] KEY_ONE  = 2'h1;
   localparam [1:0] KEY_OPEN = 2'h2;

   // both port pairs decode; the key used need not match the pair
   assign idx_hit  = (IO_ADDR_I == `SGW_IDX_ADDR_A) || (IO_ADDR_I == `SGW_IDX_ADDR_B);
   assign dat_hit  = (IO_ADDR_I == `SGW_DAT_ADDR_A) || (IO_ADDR_I == `SGW_DAT_ADDR_B);
   assign unit_hit = (IO_ADDR_I == `SGW_WDT_UNIT_ADDR);
   assign cnt_hit  = (IO_ADDR_I == `SGW_WDT_CNT_ADDR);

   // strobes and register selects for the write path; the read path decodes the index itself
   assign wr_idx   = IO_WR_I && idx_hit;
   assign wr_dat   = IO_WR_I && dat_hit && cfg_mode;
   assign wr_unit  = IO_WR_I && unit_hit;
   assign wr_cnt   = IO_WR_I && cnt_hit;
   assign is_enter = (IO_WDATA_I == `SGW_KEY_ENTER_A) || (IO_WDATA_I == `SGW_KEY_ENTER_B);
   assign sel_ldn  = (index == `SGW_IDX_LDN);
   assign sel_dir  = (logical_device_number == `SGW_LDN_GPIO) && (index == `SGW_IDX_DIR);
   assign sel_data = (logical_device_number == `SGW_LDN_GPIO) && (index == `SGW_IDX_DATA);
   assign sel_inv  = (logical_device_number == `SGW_LDN_GPIO) && (index == `SGW_IDX_INV);
   assign sel_act  = (logical_device_number == `SGW_LDN_WDT) && (index == `SGW_IDX_ACTIVATE);

   // input bits show the pin, output bits show the register
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_view
         assign data_view[g] = port_direction[g] ? pin_sample[g] : port_data[g];
      end
   endgenerate

   // entry needs the same key twice with no other index write between
   always @* begin
      next_key_state = key_state;
      if (wr_idx) begin
         case (key_state)
            KEY_IDLE: begin
               if (is_enter) begin
                  next_key_state = KEY_ONE;
               end
            end
            KEY_ONE: begin
               if (IO_WDATA_I == key_last) begin
                  next_key_state = KEY_OPEN;
               end else if (!is_enter) begin
                  next_key_state = KEY_IDLE;
               end
            end
            KEY_OPEN: begin
               if (IO_WDATA_I == `SGW_KEY_EXIT) begin
                  next_key_state = KEY_IDLE;
               end
            end
            default: begin
               next_key_state = KEY_IDLE;
            end
         endcase
      end
   end

   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         key_state <= KEY_IDLE;
         key_last  <= 8'h00;
      end else begin
         key_state <= next_key_state;
         if (wr_idx && !cfg_mode && is_enter) begin
            key_last <= IO_WDATA_I;
         end
      end
   end

   assign cfg_mode = (key_state == KEY_OPEN);

   // index register, only honoured in configuration mode
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         index <= 8'h00;
      end else if (IO_WR_I && idx_hit && cfg_mode && IO_WDATA_I != `SGW_KEY_EXIT) begin
         index <= IO_WDATA_I;
      end
   end

   // logical device number steers every later data port access except those at index 07h
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         logical_device_number <= 8'h00;
      end else if (wr_dat && sel_ldn) begin
         logical_device_number <= IO_WDATA_I;
      end
   end

   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         port_direction <= `SGW_DIR_RST;
      end else if (wr_dat && sel_dir) begin
         port_direction <= IO_WDATA_I[WIDTH-1:0];
      end
   end

   // input bits keep their value; writes only land on outputs
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         port_data <= `SGW_DATA_RST;
      end else if (wr_dat && sel_data) begin
         port_data <= (port_data & port_direction) |
                      (IO_WDATA_I[WIDTH-1:0] & ~port_direction);
      end
   end

   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         port_inversion <= `SGW_INV_RST;
      end else if (wr_dat && sel_inv) begin
         port_inversion <= IO_WDATA_I[WIDTH-1:0];
      end
   end

   // the watchdog only counts while its device is active
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         wdt_enable <= 1'b0;
      end else if (wr_dat && sel_act) begin
         wdt_enable <= IO_WDATA_I[0];
      end
   end

   // pins: sample inputs through inversion, drive outputs through inversion
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         pin_sample <= {WIDTH{1'b0}};
         GPIO_O     <= {WIDTH{1'b0}};
         GPIO_OE_O  <= {WIDTH{1'b0}};
      end else begin
         pin_sample <= GPIO_I ^ port_inversion;
         GPIO_O     <= port_data ^ port_inversion;
         GPIO_OE_O  <= ~port_direction;
      end
   end

   // read data
   always @* begin
      next_rdata = 8'hFF;
      if (dat_hit && cfg_mode) begin
         next_rdata = 8'h00;
         if (index == `SGW_IDX_LDN) begin
            next_rdata = logical_device_number;
         end else if (logical_device_number == `SGW_LDN_GPIO && index == `SGW_IDX_DIR) begin
            next_rdata[WIDTH-1:0] = port_direction;
         end else if (logical_device_number == `SGW_LDN_GPIO && index == `SGW_IDX_DATA) begin
            next_rdata[WIDTH-1:0] = data_view;
         end else if (logical_device_number == `SGW_LDN_GPIO && index == `SGW_IDX_INV) begin
            next_rdata[WIDTH-1:0] = port_inversion;
         end else if (logical_device_number == `SGW_LDN_WDT && index == `SGW_IDX_ACTIVATE) begin
            next_rdata = {7'h00, wdt_enable};
         end
      end else if (cnt_hit) begin
         next_rdata = wdt_count;
      end else if (unit_hit) begin
         next_rdata = {WDT_TIMEOUT_O, 5'h00, unit_sel};
      end
   end

   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         IO_RDATA_O  <= 8'h00;
         IO_RVALID_O <= 1'b0;
      end else begin
         IO_RVALID_O <= IO_RD_I;
         if (IO_RD_I) begin
            IO_RDATA_O <= next_rdata;
         end
      end
   end

   // a tick launched before the divider restart must not count
   assign tick_live = tick && !tick_restart;
   assign expire    = wdt_enable && wdt_running && tick_live &&
                      (wdt_count == 8'h01) && !wr_cnt;

   // unit select
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         unit_sel <= 2'd0;
      end else if (wr_unit) begin
         case (IO_WDATA_I)
            `SGW_UNIT_1S:   unit_sel <= 2'd1;
            `SGW_UNIT_1MIN: unit_sel <= 2'd2;
            default:        unit_sel <= 2'd0;
         endcase
      end
   end

   // unit and count writes both restart the divider
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         tick_restart <= 1'b1;
      end else begin
         tick_restart <= wr_unit || wr_cnt;
      end
   end

   // count reloads on every count write
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         wdt_count   <= 8'h00;
         wdt_running <= 1'b0;
      end else if (wr_cnt) begin
         wdt_count   <= IO_WDATA_I;
         wdt_running <= (IO_WDATA_I != 8'h00);
      end else if (!wdt_enable) begin
         wdt_running <= 1'b0;
      end else if (wdt_running && tick_live) begin
         wdt_count <= wdt_count - 8'h01;
         if (wdt_count == 8'h01) begin
            wdt_running <= 1'b0;
         end
      end
   end

   // expiry wins over a clear in the same cycle
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         WDT_TIMEOUT_O <= 1'b0;
      end else if (expire) begin
         WDT_TIMEOUT_O <= 1'b1;
      end else if (wr_unit) begin
         WDT_TIMEOUT_O <= 1'b0;
      end
   end

   // one pulse per expiry, routed by the mode input
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         WDT_RESET_O <= 1'b0;
         WDT_IRQ_O   <= 1'b0;
      end else begin
         WDT_RESET_O <= 1'b0;
         WDT_IRQ_O   <= 1'b0;
         if (expire) begin
            WDT_RESET_O <= !WDT_IRQ_MODE_I;
            WDT_IRQ_O   <= WDT_IRQ_MODE_I;
         end
      end
   end

   sgw_tick #(
      .CYC_10MS (CYC_10MS),
      .CYC_1S   (CYC_1S),
      .CYC_1MIN (CYC_1MIN)
   ) u_tick (
      .clk_i      (CORE_CLK_I),
      .rst_i      (RST_I),
      .restart_i  (tick_restart),
      .unit_sel_i (unit_sel),
      .tick_o     (tick)
   );

endmodule

// file: bench/sgw_props.sv
// port checker for sgw_top: host read answers and watchdog expiry
// sees only the top ports; bound from the testbench file
`timescale 1ns/1ps
module sgw_props (
   input wire        CORE_CLK_I,
   input wire        RST_I,
   input wire [15:0] IO_ADDR_I,
   input wire        IO_WR_I,
   input wire        IO_RD_I,
   input wire [7:0]  IO_RDATA_O,
   input wire        IO_RVALID_O,
   input wire        WDT_IRQ_MODE_I,
   input wire        WDT_RESET_O,
   input wire        WDT_IRQ_O,
   input wire        WDT_TIMEOUT_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // pairs 2E/2F, 4E/4F and 300/301 share all but bit 0
   wire mapped = IO_ADDR_I[15:1] == 15'h0017 || IO_ADDR_I[15:1] == 15'h0027 ||
                 IO_ADDR_I[15:1] == 15'h0180;
   wire pulse  = WDT_RESET_O || WDT_IRQ_O;
   a_read_answer: assert property (IO_RD_I |=> IO_RVALID_O)
      else $error("read got no answer");
   a_answer_cause: assert property (IO_RVALID_O |-> $past(IO_RD_I))
      else $error("answer without read");
   a_unmapped_ones: assert property (IO_RD_I && !mapped |=> IO_RDATA_O == 8'hFF)
      else $error("unmapped read not all ones");
   a_rdata_holds: assert property (!IO_RVALID_O |-> $stable(IO_RDATA_O))
      else $error("read data moved without answer");
   a_pulse_flag: assert property (pulse |-> WDT_TIMEOUT_O)
      else $error("expiry pulse without timeout flag");
   a_rise_pulses: assert property ($rose(WDT_TIMEOUT_O) |-> WDT_RESET_O != WDT_IRQ_O)
      else $error("timeout without exactly one pulse");
   a_pulse_mode: assert property (pulse |-> WDT_IRQ_O == $past(WDT_IRQ_MODE_I))
      else $error("expiry pulse on wrong output");
   a_pulse_single: assert property (pulse |=> !pulse)
      else $error("expiry pulse longer than a cycle");
   a_flag_clear: assert property ($fell(WDT_TIMEOUT_O) |->
      $past(IO_WR_I && IO_ADDR_I == 16'h0300))
      else $error("timeout flag dropped without clear");
   c_wdt_reset: cover property (WDT_RESET_O);
   c_wdt_irq: cover property (WDT_IRQ_O);
   c_read_ones: cover property (IO_RVALID_O && IO_RDATA_O == 8'hFF);
endmodule

// file: bench/sgw_host.sv
// host processor model issuing one-cycle i/o write and read strobes
// waits up to four cycles after a read strobe for the device to answer
`timescale 1ns/1ps
module sgw_host (
   input  wire        clk_i,
   input  wire [7:0]  rdata_i,
   input  wire        rvalid_i,
   output reg  [15:0] addr_o,
   output reg  [7:0]  wdata_o,
   output reg         wr_o,
   output reg         rd_o
);
   initial begin
      addr_o = 16'h0000;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   task io(input [15:0] a, input [7:0] d, input w, output [7:0] q);
      integer n;
      begin
         @(posedge clk_i);
         addr_o <= a;
         wdata_o <= d;
         wr_o <= w;
         rd_o <= !w;
         @(posedge clk_i);
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         // released lines must not keep looking valid
         addr_o <= ~a;
         wdata_o <= ~d;
         q = 8'h00;
         for (n = 0; n < 4 && !w; n = n + 1) begin
            @(posedge clk_i);
            if (rvalid_i) begin
               q = rdata_i;
               n = 4;
            end
         end
      end
   endtask
   task enter(input [15:0] a, input [7:0] k);
      reg [7:0] q;
      begin
         io(a, k, 1'b1, q);
         io(a, k, 1'b1, q);
      end
   endtask
   task cfg(input [15:0] a, input [7:0] idx, input [7:0] v, input w, output [7:0] q);
      begin
         io(a, idx, 1'b1, q);
         io(a + 16'h0001, v, w, q);
      end
   endtask
endmodule

// file: bench/sgw_tb.sv
// self-checking bench for sgw_top with host model and integer register model
// watchdog units shrunk to 10/20/30 cycles
`timescale 1ns/1ps
module testbench;
   localparam U0 = 10;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [7:0]  pin = 8'h00;
   reg         mode = 1'b0;
   reg  [7:0]  q;
   reg  [15:0] a;
   reg  [31:0] seed = 32'hAFF59BFE;
   wire [15:0] addr;
   wire [7:0]  wd, rdata, gpo, oe;
   wire        wr, rd, rv, wres, wirq, wto;
   integer     error_cnt = 0, compares = 0, dir, dat, inv, i, n, e, mdl = 0;
   always #5 clk = ~clk;
   sgw_top #(.CYC_10MS(U0), .CYC_1S(2 * U0), .CYC_1MIN(3 * U0)) dut (.CORE_CLK_I(clk),
      .RST_I(rst), .IO_ADDR_I(addr), .IO_WDATA_I(wd), .IO_WR_I(wr), .IO_RD_I(rd),
      .IO_RDATA_O(rdata), .IO_RVALID_O(rv), .GPIO_I(pin), .GPIO_O(gpo), .GPIO_OE_O(oe),
      .WDT_IRQ_MODE_I(mode), .WDT_RESET_O(wres), .WDT_IRQ_O(wirq), .WDT_TIMEOUT_O(wto));
   sgw_host h (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rv), .addr_o(addr), .wdata_o(wd),
      .wr_o(wr), .rd_o(rd));
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task check(input [95:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task finish_test;
      begin
         $display("compares %0d errors %0d", compares, error_cnt);
         if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task do_reset;
      begin
         @(posedge clk);
         rst <= 1'b1;
         repeat (20) @(posedge clk);
         rst <= 1'b0;
         @(posedge clk);
         check("oe_rst", oe, 0);
      end
   endtask
   initial begin
      #300000;
      error_cnt = error_cnt + 1;
      finish_test;
   end
   initial begin
      do_reset;
      h.io(16'h0123, 8'h00, 1'b0, q);
      check("unmapped", q, 8'hFF);
      h.io(16'h002E, 8'h87, 1'b1, q);
      h.io(16'h002E, 8'h07, 1'b1, q);
      h.io(16'h002E, 8'h87, 1'b1, q);
      h.io(16'h002F, 8'h00, 1'b0, q);
      check("locked", q, 8'hFF);
      h.enter(16'h002E, 8'h87);
      h.cfg(16'h002E, 8'h07, 8'h07, 1'b1, q);
      h.cfg(16'h002E, 8'hF0, 8'h00, 1'b0, q);
      check("dir_rst", q, 8'hFF);
      h.cfg(16'h004E, 8'hF2, 8'h00, 1'b0, q);
      check("inv_rst", q, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         a = i[0] ? 16'h004E : 16'h002E;
         seed = lfsr(seed);
         h.cfg(a, 8'hF0, seed[7:0], 1'b1, q);
         h.cfg(a, 8'hF2, seed[15:8], 1'b1, q);
         pin <= seed[31:24];
         h.cfg(a, 8'hF1, seed[23:16], 1'b1, q);
         dir = seed[7:0];
         inv = seed[15:8];
         // input bits read back the corrected pin, writes to them are lost
         mdl = (seed[23:16] & ~dir) | (mdl & dir);
         dat = (mdl & ~dir) | ((pin ^ inv) & dir);
         repeat (3) @(posedge clk);
         check("oe", oe, ~dir & 255);
         check("drive", gpo & ~dir, (dat ^ inv) & ~dir & 255);
         h.cfg(a, 8'hF1, 8'h00, 1'b0, q);
         check("data", q, dat);
         h.cfg(a, 8'hF0, 8'h00, 1'b0, q);
         check("dir", q, dir);
         h.cfg(a, 8'hF2, 8'h00, 1'b0, q);
         check("inv", q, inv);
         // all outputs now: bits written while inputs must still hold the old value
         h.cfg(a, 8'hF0, 8'h00, 1'b1, q);
         repeat (3) @(posedge clk);
         check("kept", gpo, (mdl ^ inv) & 255);
      end
      h.io(16'h002E, 8'hAA, 1'b1, q);
      h.io(16'h002F, 8'h00, 1'b0, q);
      check("exited", q, 8'hFF);
      do_reset;
      h.enter(16'h004E, 8'h77);
      h.cfg(16'h004E, 8'h07, 8'h08, 1'b1, q);
      h.cfg(16'h004E, 8'h30, 8'h01, 1'b1, q);
      h.io(16'h004E, 8'hAA, 1'b1, q);
      for (i = 0; i < 4; i = i + 1) begin
         mode <= i[0];
         if (i == 3) begin
            h.enter(16'h004E, 8'h77);
            h.cfg(16'h004E, 8'h30, 8'h00, 1'b1, q);
            h.io(16'h004E, 8'hAA, 1'b1, q);
         end
         h.io(16'h0300, i == 0 ? 8'h00 : (i == 1 ? 8'h03 : 8'h05), 1'b1, q);
         h.io(16'h0300, 8'h00, 1'b0, q);
         check("status", q[7], 0);
         check("to_clear", wto, 0);
         h.io(16'h0301, i == 0 ? 8'h14 : 8'h02, 1'b1, q);
         repeat (U0) @(posedge clk);
         h.io(16'h0301, i == 0 ? 8'h14 : 8'h02, 1'b1, q);
         e = (i == 0 ? 20 : 2) * U0 * (i == 3 ? 3 : i + 1);
         n = 0;
         while (wto !== 1'b1 && n < e + 40) begin
            @(posedge clk);
            n = n + 1;
         end
         if (i < 3) begin
            check("expiry", n >= e - 2 && n <= e + 4, 1);
            check("rst_pulse", wres, !mode);
            check("irq_pulse", wirq, mode);
            h.io(16'h0301, 8'h00, 1'b0, q);
            check("cnt_rd", q, 0);
            repeat (50) @(posedge clk);
         end
         check("sticky", wto, i < 3);
      end
      finish_test;
   end
endmodule
bind sgw_top sgw_props chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .IO_ADDR_I(IO_ADDR_I),
   .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I), .IO_RDATA_O(IO_RDATA_O), .IO_RVALID_O(IO_RVALID_O),
   .WDT_IRQ_MODE_I(WDT_IRQ_MODE_I), .WDT_RESET_O(WDT_RESET_O), .WDT_IRQ_O(WDT_IRQ_O),
   .WDT_TIMEOUT_O(WDT_TIMEOUT_O));
